// *** include/dtsr_pkg.sv ***
// package: register map, field positions and reset values of the trace status block
`default_nettype none
package dtsr_pkg;
  localparam int          DTSR_ADDR_W        = 4;
  localparam logic [3:0]  DTSR_STATUS_OFS    = 4'h0;  // trace_status_reg, read only
  localparam logic [3:0]  DTSR_CONTROL_OFS   = 4'h4;  // trace_control_reg
  localparam logic [3:0]  DTSR_EVENT_OFS     = 4'h8;  // run event pulses written by software for test
  localparam int          DTSR_MATCH_A_BIT   = 7;
  localparam int          DTSR_MATCH_B_BIT   = 6;
  localparam int          DTSR_ACTIVE_BIT    = 5;
  localparam int          DTSR_CTL_ON_BIT    = 7;     // trace_module_on in control
  localparam int          DTSR_CTL_ARM_BIT   = 6;     // arm bit in control
  localparam int          DTSR_CTL_MODE_BIT  = 5;     // 1 = end-trace, 0 = begin-trace
  localparam int          DTSR_TALLY_W       = 4;
  localparam logic [3:0]  DTSR_TALLY_RST     = 4'h0;
  localparam logic [7:0]  DTSR_CONTROL_RST   = 8'h00;
  localparam logic [1:0]  DTSR_RESP_OKAY     = 2'b00;
  localparam logic [1:0]  DTSR_RESP_SLVERR   = 2'b10;
  localparam logic [1:0]  DTSR_RESP_DECERR   = 2'b11;
endpackage : dtsr_pkg
`default_nettype wire

// *** include/dtsr_run_if.sv ***
// interface: run control and status between bus slave and the run tracker
`timescale 1ns/100ps
`default_nettype none
interface dtsr_run_if;
  logic       module_on;
  logic       arm;
  logic       end_mode;
  logic       arm_wr;
  logic       match_a;
  logic       match_b;
  logic       fifo_full;
  logic       trigger;
  logic [3:0] fifo_words;
  logic       run_start;
  logic       run_done;
  logic       match_a_flag;
  logic       comparator_b_hit;
  logic       capture_active;
  logic [3:0] valid_word_tally;
  modport ctl (output module_on, arm, end_mode, arm_wr, match_a, match_b, fifo_full,
               trigger, fifo_words,
               input  run_start, run_done, match_a_flag, comparator_b_hit,
               capture_active, valid_word_tally);
  modport trk (input  module_on, arm, end_mode, arm_wr, match_a, match_b, fifo_full,
               trigger, fifo_words,
               output run_start, run_done, match_a_flag, comparator_b_hit,
               capture_active, valid_word_tally);
endinterface : dtsr_run_if
`default_nettype wire

// *** rtl/dtsr_run.sv ***
// run tracker: match flags, armed state and valid word tally
`timescale 1ns/100ps
`default_nettype none
module dtsr_run
  import dtsr_pkg::*;
(
  input  wire logic CORE_CLK,   // bus clock
  input  wire logic RST_N,      // async reset, active low
  dtsr_run_if.trk   run         // run control and status
);
  logic       match_a_flag;
  logic       comparator_b_hit;
  logic       capture_active;
  logic [3:0] valid_word_tally;

  // run start on arm write with module on; run end by completion or manual stop
  wire arm_req   = run.arm_wr & run.arm & run.module_on;
  wire complete  = run.end_mode ? run.trigger : run.fifo_full;
  wire manual    = ~run.arm | ~run.module_on;
  wire stop      = capture_active & (complete | manual);
  wire next_act  = arm_req ? 1'b1 : (stop ? 1'b0 : capture_active);

  assign run.run_start        = arm_req;
  assign run.run_done         = stop;
  assign run.match_a_flag     = match_a_flag;
  assign run.comparator_b_hit = comparator_b_hit;
  // armed bit shows the armed state only while module on
  assign run.capture_active   = capture_active & run.module_on;
  assign run.valid_word_tally = valid_word_tally;

  // armed state
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      capture_active <= 1'b0;
    end else begin
      capture_active <= next_act;
    end
  end

  // match flags: cleared at run start, set while armed, held until next start
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      match_a_flag     <= 1'b0;
      comparator_b_hit <= 1'b0;
    end else if (arm_req) begin
      match_a_flag     <= 1'b0;
      comparator_b_hit <= 1'b0;
    end else if (capture_active) begin
      match_a_flag     <= match_a_flag | run.match_a;
      comparator_b_hit <= comparator_b_hit | run.match_b;
    end
  end

  // tally: cleared at start, captured at run end, untouched by fifo reads
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      valid_word_tally <= DTSR_TALLY_RST;
    end else if (arm_req) begin
      valid_word_tally <= DTSR_TALLY_RST;
    end else if (stop) begin
      valid_word_tally <= run.fifo_words;
    end
  end
endmodule : dtsr_run
`default_nettype wire

// *** rtl/dtsr_top.sv ***
// top: AXI4-Lite slave holding trace status and control
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module dtsr_top
  import dtsr_pkg::*;
(
  input  wire logic        CORE_CLK,       // bus clock 25 MHz
  input  wire logic        RST_N,          // async reset, active low
  input  wire logic [3:0]  S_AXI_AWADDR,   // write address
  input  wire logic [2:0]  S_AXI_AWPROT,   // write protection, unused
  input  wire logic        S_AXI_AWVALID,  // write address valid
  output logic             S_AXI_AWREADY,  // write address ready
  input  wire logic [31:0] S_AXI_WDATA,    // write data
  input  wire logic [3:0]  S_AXI_WSTRB,    // write strobes
  input  wire logic        S_AXI_WVALID,   // write data valid
  output logic             S_AXI_WREADY,   // write data ready
  output logic [1:0]       S_AXI_BRESP,    // write response
  output logic             S_AXI_BVALID,   // write response valid
  input  wire logic        S_AXI_BREADY,   // write response ready
  input  wire logic [3:0]  S_AXI_ARADDR,   // read address
  input  wire logic [2:0]  S_AXI_ARPROT,   // read protection, unused
  input  wire logic        S_AXI_ARVALID,  // read address valid
  output logic             S_AXI_ARREADY,  // read address ready
  output logic [31:0]      S_AXI_RDATA,    // read data
  output logic [1:0]       S_AXI_RRESP,    // read response
  output logic             S_AXI_RVALID,   // read data valid
  input  wire logic        S_AXI_RREADY,   // read data ready
  input  wire logic        MATCH_A,        // comparator A match, bus clock
  input  wire logic        MATCH_B,        // comparator B match, bus clock
  input  wire logic        FIFO_FULL,      // trace fifo full, bus clock
  input  wire logic        TRIGGER,        // trigger event detected, bus clock
  input  wire logic [3:0]  FIFO_WORDS,     // valid words in fifo, bus clock
  output logic             RUN_ARMED,      // debugger armed
  output logic             RUN_START,      // pulse at run start
  output logic             RUN_DONE        // pulse at run end
);
  dtsr_run_if run ();

  logic [7:0]  trace_control_reg;
  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        bvalid;
  logic [1:0]  bresp;
  logic        rvalid;
  logic [1:0]  rresp;
  logic [31:0] rdata;

  // write channel capture: address and data taken in either order
  wire aw_take   = S_AXI_AWVALID & ~aw_held & ~bvalid;
  wire w_take    = S_AXI_WVALID & ~w_held & ~bvalid;
  wire aw_have   = aw_held | aw_take;
  wire w_have    = w_held | w_take;
  wire wr_fire   = aw_have & w_have & ~bvalid;
  wire [3:0] wa  = aw_held ? aw_addr : S_AXI_AWADDR;
  wire [31:0] wd = w_held ? w_data : S_AXI_WDATA;
  wire [3:0] ws  = w_held ? w_strb : S_AXI_WSTRB;

  // write decode
  wire wr_status  = wr_fire & (wa == DTSR_STATUS_OFS);
  wire wr_control = wr_fire & (wa == DTSR_CONTROL_OFS) & ws[0];
  wire wr_ctl_any = wr_fire & (wa == DTSR_CONTROL_OFS);
  wire wr_event   = wr_fire & (wa == DTSR_EVENT_OFS);
  wire wr_mapped  = wr_status | wr_ctl_any | wr_event;
  wire [1:0] next_bresp = wr_status ? DTSR_RESP_SLVERR
                        : (wr_mapped ? DTSR_RESP_OKAY : DTSR_RESP_DECERR);

  assign S_AXI_AWREADY = ~aw_held & ~bvalid;
  assign S_AXI_WREADY  = ~w_held & ~bvalid;
  assign S_AXI_BVALID  = bvalid;
  assign S_AXI_BRESP   = bresp;

  // hold captured write address and data until both present
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      aw_held <= aw_have & ~wr_fire;
      w_held  <= w_have & ~wr_fire;
      if (aw_take) begin
        aw_addr <= S_AXI_AWADDR;
      end
      if (w_take) begin
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
    end
  end

  // write response
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bvalid <= 1'b0;
      bresp  <= DTSR_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= next_bresp;
    end else if (S_AXI_BREADY) begin
      bvalid <= 1'b0;
    end
  end

  // control register; a status write is answered but stores nothing
  wire [7:0] next_control = {wd[7:5], 5'h00};                       // unused bits read zero
  wire       auto_clear   = run.run_done & ~wr_control;              // arm drops with armed
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      trace_control_reg <= DTSR_CONTROL_RST;
    end else if (wr_control) begin
      trace_control_reg <= next_control;
    end else if (auto_clear) begin
      trace_control_reg[DTSR_CTL_ARM_BIT] <= 1'b0;
    end
  end

  // event register: software may pulse events for test (bits 0..3)
  wire ev_a    = wr_event & ws[0] & wd[0];
  wire ev_b    = wr_event & ws[0] & wd[1];
  wire ev_full = wr_event & ws[0] & wd[2];
  wire ev_trig = wr_event & ws[0] & wd[3];

  // connections to run tracker
  assign run.module_on  = wr_control ? next_control[DTSR_CTL_ON_BIT]
                                     : trace_control_reg[DTSR_CTL_ON_BIT];
  assign run.arm        = wr_control ? next_control[DTSR_CTL_ARM_BIT]
                                     : trace_control_reg[DTSR_CTL_ARM_BIT];
  assign run.end_mode   = trace_control_reg[DTSR_CTL_MODE_BIT];
  assign run.arm_wr     = wr_control & next_control[DTSR_CTL_ARM_BIT]
                          & next_control[DTSR_CTL_ON_BIT];
  assign run.match_a    = MATCH_A | ev_a;
  assign run.match_b    = MATCH_B | ev_b;
  assign run.fifo_full  = FIFO_FULL | ev_full;
  assign run.trigger    = TRIGGER | ev_trig;
  assign run.fifo_words = FIFO_WORDS;

  dtsr_run u_run (
    .CORE_CLK (CORE_CLK),
    .RST_N    (RST_N),
    .run      (run)
  );

  // status image; bit 4 reads zero
  wire [7:0] trace_status_reg = {run.match_a_flag, run.comparator_b_hit,
                                 run.capture_active, 1'b0,
                                 run.valid_word_tally};

  // read decode
  wire rd_take    = S_AXI_ARVALID & ~rvalid;
  wire rd_status  = (S_AXI_ARADDR == DTSR_STATUS_OFS);
  wire rd_control = (S_AXI_ARADDR == DTSR_CONTROL_OFS);
  wire rd_event   = (S_AXI_ARADDR == DTSR_EVENT_OFS);
  wire [31:0] next_rdata = rd_status  ? {24'h00_0000, trace_status_reg}
                         : (rd_control ? {24'h00_0000, trace_control_reg}
                                       : 32'h0000_0000);
  wire [1:0] next_rresp  = (rd_status | rd_control | rd_event) ? DTSR_RESP_OKAY
                                                               : DTSR_RESP_DECERR;

  assign S_AXI_ARREADY = ~rvalid;
  assign S_AXI_RVALID  = rvalid;
  assign S_AXI_RDATA   = rdata;
  assign S_AXI_RRESP   = rresp;

  // read response
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= DTSR_RESP_OKAY;
    end else if (rd_take) begin
      rvalid <= 1'b1;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end else if (S_AXI_RREADY) begin
      rvalid <= 1'b0;
    end
  end

  // run outputs
  assign RUN_ARMED = run.capture_active;
  assign RUN_START = run.run_start;
  assign RUN_DONE  = run.run_done;
endmodule : dtsr_top
`default_nettype wire

// *** tb/dtsr_top_props.sv ***
// checker: port-level properties of the trace status block
`timescale 1ns/100ps
`default_nettype none
module dtsr_top_props (
  input wire logic        CORE_CLK,      // clock
  input wire logic        RST_N,         // reset
  input wire logic [1:0]  S_AXI_BRESP,   // write resp
  input wire logic        S_AXI_BVALID,  // b valid
  input wire logic        S_AXI_BREADY,  // b ready
  input wire logic        S_AXI_ARREADY, // ar ready
  input wire logic [31:0] S_AXI_RDATA,   // read data
  input wire logic        S_AXI_RVALID,  // r valid
  input wire logic        S_AXI_RREADY,  // r ready
  input wire logic        RUN_ARMED,     // armed
  input wire logic        RUN_START,     // run start
  input wire logic        RUN_DONE       // run end
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // run end drops the armed state
  sequence s_disarm; ##1 !RUN_ARMED; endsequence
  sequence s_arming; ##1 RUN_ARMED; endsequence
  property p_done; RUN_DONE && !RUN_START |-> s_disarm; endproperty
  property p_start; RUN_START |-> s_arming; endproperty
  property p_rsv; S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0 && !S_AXI_RDATA[4]; endproperty
  property p_rhold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  property p_bhold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  property p_arrdy; S_AXI_ARREADY != S_AXI_RVALID; endproperty
  property p_bresp; S_AXI_BVALID |-> S_AXI_BRESP != 2'b01; endproperty
  property p_rdrop; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID; endproperty
  a_done: assert property (p_done) else $error("armed not cleared at run end");
  a_start: assert property (p_start) else $error("arming did not set armed");
  a_rsv: assert property (p_rsv) else $error("unused status bits not zero");
  a_rhold: assert property (p_rhold) else $error("read data not held");
  a_bhold: assert property (p_bhold) else $error("write response not held");
  a_arrdy: assert property (p_arrdy) else $error("arready not inverse of rvalid");
  a_bresp: assert property (p_bresp) else $error("illegal write response");
  a_rdrop: assert property (p_rdrop) else $error("rvalid stays after handshake");
endmodule // dtsr_top_props
bind dtsr_top dtsr_top_props u_dtsr_top_props (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .RUN_ARMED(RUN_ARMED), .RUN_START(RUN_START),
  .RUN_DONE(RUN_DONE));
`default_nettype wire

// *** tb/dtsr_top_bench.sv ***
// bench: bus-level tests of the trace status block
`timescale 1ns/100ps
`default_nettype none
module dtsr_top_bench;
  import dtsr_pkg::*;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, armed, start, done;
  logic [3:0]  awaddr, araddr, wstrb, ev, words;
  logic [31:0] wdata, rdata, dat;
  logic [1:0]  bresp, rresp, resp;
  int          bad_count, n_compared;
  dtsr_top u_dtsr_top (.CORE_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .MATCH_A(ev[0]), .MATCH_B(ev[1]),
    .FIFO_FULL(ev[2]), .TRIGGER(ev[3]), .FIFO_WORDS(words), .RUN_ARMED(armed),
    .RUN_START(start), .RUN_DONE(done));
  // 25 mhz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // axi write, late bready
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b1;
    @(posedge clk);
    resp = bresp;
    bready <= 1'b0;
  endtask
  // axi read, late rready
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b1;
    @(posedge clk);
    dat = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rs(input logic [7:0] e);
    rd(DTSR_STATUS_OFS);
    chk("status", dat, {24'h0, e});
  endtask
  // one-cycle event pulse with fifo level
  task automatic pulse(input logic [3:0] b, input logic [3:0] w);
    @(posedge clk);
    ev <= b;
    words <= w;
    @(posedge clk);
    ev <= 4'h0;
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    end_sim;
  end
  // test sequence
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, ev, words, wdata} = '0;
    wstrb = 4'hf;
    bad_count = 0;
    n_compared = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rs(8'h00);
    wr(DTSR_CONTROL_OFS, 8'hc0);
    rs(8'h20);
    pulse(4'h1, 4'h0);
    rs(8'ha0);
    pulse(4'h4, 4'h8);
    rs(8'h88);
    rd(DTSR_CONTROL_OFS);
    chk("control", dat, 32'h80);
    pulse(4'h2, 4'h3);
    rs(8'h88);
    wr(DTSR_STATUS_OFS, 8'h00);
    chk("status wr resp", {30'h0, resp}, {30'h0, DTSR_RESP_SLVERR});
    rs(8'h88);
    wr(DTSR_CONTROL_OFS, 8'he0);
    rs(8'h20);
    pulse(4'h6, 4'h4);
    rs(8'h60);
    pulse(4'h8, 4'h5);
    rs(8'h45);
    wr(DTSR_CONTROL_OFS, 8'he0);
    pulse(4'h0, 4'h2);
    wr(DTSR_CONTROL_OFS, 8'ha0);
    rs(8'h02);
    wr(DTSR_CONTROL_OFS, 8'he0);
    wr(DTSR_CONTROL_OFS, 8'h60);
    rs(8'h02);
    wr(DTSR_CONTROL_OFS, 8'hc0);
    wr(DTSR_EVENT_OFS, 8'h05);
    chk("event bresp", {30'h0, resp}, {30'h0, DTSR_RESP_OKAY});
    rs(8'h82);
    rd(DTSR_CONTROL_OFS);
    chk("control after event", dat, 32'h80);
    rd(DTSR_EVENT_OFS);
    chk("event rdata", dat, 32'h0);
    rd(4'hc);
    chk("unmapped rresp", {30'h0, resp}, {30'h0, DTSR_RESP_DECERR});
    chk("unmapped rdata", dat, 32'h0);
    wr(4'hc, 8'h5a);
    chk("unmapped bresp", {30'h0, resp}, {30'h0, DTSR_RESP_DECERR});
    end_sim;
  end
endmodule // dtsr_top_bench
`default_nettype wire
